// ===== inc/dcm_pkg.sv
// constants and types shared by the dma channel enable and mask control block
package dcm_pkg;
  localparam int unsigned NUM_CH = 14;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;
  typedef logic [NUM_CH-1:0] dcm_ch_t;
  // register byte addresses
  localparam logic [ADDR_W-1:0] MASK_SET_ADDR   = 32'h4001_0020;
  localparam logic [ADDR_W-1:0] MASK_CLEAR_ADDR = 32'h4001_0024;
  localparam logic [ADDR_W-1:0] EN_SET_ADDR     = 32'h4001_0028;
  localparam logic [ADDR_W-1:0] EN_CLEAR_ADDR   = 32'h4001_002c;
  localparam logic [ADDR_W-1:0] REQ_STAT_ADDR   = 32'h4001_0040;
  // reset values
  localparam dcm_ch_t CH_RESET = 14'h0000;
  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;
  localparam int unsigned HI_PAD_W = DATA_W - NUM_CH;
  localparam logic [HI_PAD_W-1:0] HI_PAD = 18'h00000;
  typedef enum logic [1:0] {
    DCM_DEC_NONE,
    DCM_DEC_MASK_SET,
    DCM_DEC_MASK_CLR,
    DCM_DEC_EN
  } dcm_dec_t;
endpackage

// ===== hdl/dcm_req_sync.sv
// two flip-flop synchroniser for the peripheral request lines
`timescale 1ns/1ns
module dcm_req_sync (
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire dcm_pkg::dcm_ch_t async_in,
  output dcm_pkg::dcm_ch_t     sync_out
);
  import dcm_pkg::*;
  typedef struct packed {
    dcm_ch_t meta;
    dcm_ch_t sync;
  } dcm_sync_state_t;
  dcm_sync_state_t st_reg;
  dcm_sync_state_t st_next;

  // first stage feeds only the second stage
  always_comb begin
    st_next.meta = async_in;
    st_next.sync = st_reg.meta;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '{meta: CH_RESET, sync: CH_RESET};
    end else begin
      st_reg <= st_next;
    end
  end

  assign sync_out = st_reg.sync;
endmodule

// ===== hdl/dcm_ch_bit.sv
// one channel's enable and request mask state with request gating
`timescale 1ns/1ns
module dcm_ch_bit (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic en_set,
  input  wire logic en_clear,
  input  wire logic done,
  input  wire logic mask_set,
  input  wire logic mask_clear,
  input  wire logic req_in,
  output logic      enabled,
  output logic      masked,
  output logic      req_out
);
  typedef struct packed {
    logic en;
    logic msk;
    logic req;
  } dcm_bit_state_t;
  dcm_bit_state_t st_reg;
  dcm_bit_state_t st_next;

  // set wins over clear when both land in one cycle so no write is lost
  always_comb begin
    st_next = st_reg;
    if (en_set) begin
      st_next.en = 1'b1;
    end else if (en_clear || done) begin
      st_next.en = 1'b0;
    end
    if (mask_set) begin
      st_next.msk = 1'b1;
    end else if (mask_clear) begin
      st_next.msk = 1'b0;
    end
    // masked channel passes no peripheral request
    st_next.req = req_in && !st_reg.msk && st_reg.en;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '{en: 1'b0, msk: 1'b0, req: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign enabled = st_reg.en;
  assign masked  = st_reg.msk;
  assign req_out = st_reg.req;
endmodule

// ===== hdl/dcm_ctrl.sv
// apb register slave for dma channel enable and request mask control
`timescale 1ns/1ns
module dcm_ctrl (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [dcm_pkg::ADDR_W-1:0] paddr,
  input  wire logic [dcm_pkg::DATA_W-1:0] pwdata,
  output logic [dcm_pkg::DATA_W-1:0]    prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire dcm_pkg::dcm_ch_t         periph_req,
  input  wire dcm_pkg::dcm_ch_t         cycle_done,
  output dcm_pkg::dcm_ch_t              ch_enabled,
  output dcm_pkg::dcm_ch_t              ch_req
);
  import dcm_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic              ready;
    logic              err;
    dcm_ch_t           en_out;
  } dcm_bus_state_t;
  dcm_bus_state_t st_reg;
  dcm_bus_state_t st_next;

  dcm_ch_t  req_sync;
  dcm_ch_t  en_bits;
  dcm_ch_t  msk_bits;
  dcm_ch_t  req_bits;
  dcm_ch_t  wr_en_set;
  dcm_ch_t  wr_en_clr;
  dcm_ch_t  wr_msk_set;
  dcm_ch_t  wr_msk_clr;
  dcm_dec_t dec;
  logic     acc;
  logic     wr_acc;
  logic     hit;

  // peripheral requests come from outside this clock domain
  dcm_req_sync u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (periph_req),
    .sync_out (req_sync)
  );

  // address decode; enable-set and enable-clear share one read view
  always_comb begin
    dec = DCM_DEC_NONE;
    hit = 1'b1;
    if (paddr == MASK_SET_ADDR) begin
      dec = DCM_DEC_MASK_SET;
    end else if (paddr == MASK_CLEAR_ADDR) begin
      dec = DCM_DEC_MASK_CLR;
    end else if (paddr == EN_SET_ADDR || paddr == EN_CLEAR_ADDR) begin
      dec = DCM_DEC_EN;
    end else if (paddr == REQ_STAT_ADDR) begin
      dec = DCM_DEC_NONE;
    end else begin
      hit = 1'b0;
    end
  end

  // writes take effect only at the completing access edge
  assign acc    = psel && penable && st_reg.ready;
  assign wr_acc = acc && pwrite;

  // only ones in the written word act, zeros are ignored
  assign wr_en_set  = (wr_acc && paddr == EN_SET_ADDR)     ? pwdata[NUM_CH-1:0] : CH_RESET;
  assign wr_en_clr  = (wr_acc && paddr == EN_CLEAR_ADDR)   ? pwdata[NUM_CH-1:0] : CH_RESET;
  assign wr_msk_set = (wr_acc && paddr == MASK_SET_ADDR)   ? pwdata[NUM_CH-1:0] : CH_RESET;
  assign wr_msk_clr = (wr_acc && paddr == MASK_CLEAR_ADDR) ? pwdata[NUM_CH-1:0] : CH_RESET;

  // one state cell per channel, bit C drives channel C
  genvar c;
  generate
    for (c = 0; c < NUM_CH; c++) begin : g_ch
      dcm_ch_bit u_bit (
        .pclk       (pclk),
        .presetn    (presetn),
        .en_set     (wr_en_set[c]),
        .en_clear   (wr_en_clr[c]),
        .done       (cycle_done[c]),
        .mask_set   (wr_msk_set[c]),
        .mask_clear (wr_msk_clr[c]),
        .req_in     (req_sync[c]),
        .enabled    (en_bits[c]),
        .masked     (msk_bits[c]),
        .req_out    (req_bits[c])
      );
    end
  endgenerate

  // one wait state: ready rises in the second access cycle, low otherwise
  always_comb begin
    st_next        = st_reg;
    st_next.ready  = psel && penable && !st_reg.ready;
    st_next.err    = 1'b0;
    st_next.rdata  = ZERO_WORD;
    st_next.en_out = en_bits;
    if (psel && penable && !st_reg.ready) begin
      st_next.err = !hit;
      if (!pwrite && hit) begin
        if (dec == DCM_DEC_EN) begin
          st_next.rdata = {HI_PAD, en_bits};
        end else if (dec == DCM_DEC_MASK_SET) begin
          st_next.rdata = {HI_PAD, msk_bits};
        end else if (paddr == REQ_STAT_ADDR) begin
          st_next.rdata = {HI_PAD, req_bits};
        end else begin
          st_next.rdata = ZERO_WORD; // mask-clear is write only
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '{rdata: ZERO_WORD, ready: 1'b0, err: 1'b0, en_out: CH_RESET};
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata     = st_reg.rdata;
  assign pready     = st_reg.ready;
  assign pslverr    = st_reg.err;
  assign ch_enabled = st_reg.en_out;
  assign ch_req     = req_bits;
endmodule

// ===== verif/dcm_periph_model.sv
// peripheral side: per-channel request levels raised by the bench
`timescale 1ns/1ns
module dcm_periph_model (
  input  wire logic             pclk,
  input  wire dcm_pkg::dcm_ch_t want,
  output dcm_pkg::dcm_ch_t      periph_req
);
  import dcm_pkg::*;
  // level registered from want a cycle later, held until the bench changes want
  always_ff @(posedge pclk) begin
    periph_req <= want;
  end
endmodule

// ===== verif/dcm_ctrl_checker.sv
// port assertions for the dma enable and mask control block
`timescale 1ns/1ns
module dcm_ctrl_checker (
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [31:0]      paddr,
  input wire logic [31:0]      pwdata,
  input wire logic [31:0]      prdata,
  input wire logic             pready,
  input wire dcm_pkg::dcm_ch_t cycle_done,
  input wire dcm_pkg::dcm_ch_t ch_enabled,
  input wire dcm_pkg::dcm_ch_t ch_req
);
  import dcm_pkg::*;
  // taken writes; ch_enabled lags the state by a cycle, hence ##2
  wire tk = psel & penable & pready;
  wire ts = tk & pwrite & (paddr == EN_SET_ADDR);
  wire tc = tk & pwrite & (paddr == EN_CLEAR_ADDR);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  chk_one_wait: assert property ($rose(penable) && psel |=> pready)
    else $error("ready late");
  chk_set_on: assert property (ts |-> ##2 &(ch_enabled | ~$past(pwdata[13:0], 2)))
    else $error("set missed");
  chk_clr_off: assert property (tc |-> ##2 (ch_enabled & $past(pwdata[13:0], 2)) == 14'h0)
    else $error("clear missed");
  chk_done_off: assert property (|cycle_done && !ts |-> ##2 (ch_enabled & $past(cycle_done, 2)) == 14'h0)
    else $error("done kept enable");
  chk_only_set: assert property ((ch_enabled & ~$past(ch_enabled)) != 14'h0 |-> $past(ts, 2))
    else $error("enable without set");
  chk_only_clr: assert property (($past(ch_enabled) & ~ch_enabled) != 14'h0 |->
    $past(tc, 2) || $past(cycle_done, 2) != 14'h0)
    else $error("disable without cause");
  chk_read_en: assert property (tk && !pwrite && paddr[31:3] == EN_SET_ADDR[31:3] |->
    prdata == {18'h0, ch_enabled})
    else $error("enable readback");
  chk_req_gate: assert property ((ch_req & ~ch_enabled) == 14'h0)
    else $error("request not gated");
endmodule
bind dcm_ctrl dcm_ctrl_checker chk (.*);

// ===== verif/tb_top.sv
// self-checking bench: register rows, request gating, completion, reset
`timescale 1ns/1ns
module tb_top;
  import dcm_pkg::*;
  typedef struct {logic w; logic [7:0] a; logic [13:0] d;} dcm_row_t;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        pready, pslverr, err;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
  dcm_ch_t     want = 14'h0, cycle_done = 14'h0, periph_req, ch_enabled, ch_req;
  int          errors = 0, num_checks = 0, cyc = 0;
  // writes carry data, reads carry the expected word; 0x50 is unmapped
  dcm_row_t rows [16] = '{'{0, 8'h28, 14'h0}, '{0, 8'h20, 14'h0}, '{1, 8'h28, 14'h2001},
    '{0, 8'h28, 14'h2001}, '{1, 8'h28, 14'h0}, '{0, 8'h2c, 14'h2001}, '{1, 8'h2c, 14'h1},
    '{0, 8'h28, 14'h2000}, '{1, 8'h20, 14'h3fff}, '{0, 8'h20, 14'h3fff}, '{1, 8'h24, 14'h4},
    '{0, 8'h20, 14'h3ffb}, '{1, 8'h24, 14'h0}, '{0, 8'h20, 14'h3ffb}, '{0, 8'h24, 14'h0},
    '{0, 8'h50, 14'h0}};
  always #2 pclk = ~pclk;
  dcm_ctrl dut (.*);
  dcm_periph_model peri (.*);
  // hang guard, far above the roughly 110 cycles the run needs
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      test_done;
    end
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // one apb transfer; held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [13:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {24'h400100, a};
    pwdata <= {18'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk("slverr", err, rows[i].a == 8'h50);
      if (!rows[i].w) chk("read", rd, rows[i].d);
    end
    $display("test register rows done");
    apb(1'b1, 8'h24, 14'h3fff);
    apb(1'b1, 8'h28, 14'h20);
    want <= 14'h24;
    repeat (6) @(posedge pclk);
    chk("gated req", ch_req, 14'h20);
    apb(1'b1, 8'h20, 14'h20);
    repeat (4) @(posedge pclk);
    chk("masked req", ch_req, 14'h0);
    cycle_done <= 14'h20;
    @(posedge pclk);
    cycle_done <= 14'h0;
    apb(1'b0, 8'h2c, 14'h0);
    chk("done clears", rd, 32'h2000);
    $display("test gating and completion done");
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h28, 14'h0);
    chk("reset enable", rd, 32'h0);
    apb(1'b0, 8'h20, 14'h0);
    chk("reset mask", rd, 32'h0);
    $display("test second reset done");
    test_done;
  end
endmodule
